// file: rtl/rmu_remainder_unit.v
// integer and real remainder datapath with arithmetic controls and status
// Function
// - integer overflow only on signed form, mask clear, like signs, flipped result
// - long real register operands name the lower, even register of a pair
// - infinite divisor with finite or zero dividend returns the dividend
// - a zero real result carries the dividend sign
// - real remainder is exact when destination is as wide as sources
// - remainder is dividend minus truncated quotient times divisor
// - penultimate quotient bit to status bit 6, last to bit 5
// - next reduction quotient bit to bit 4; bit 3 if that remainder nonzero
// - denormal operand with normalizing mode set raises reserved-encoding fault
// - each floating exception faults only when its mask bit allows
// - finite nonzero dividend over zero divisor raises zero-divide; real zero over zero is invalid, integer raises zero-divide
// - infinite dividend or signaling NaN is invalid; quiet NaN gives NaN
// - result too large or too small raises overflow or underflow
// - result not exactly representable raises inexact
`timescale 1ns/100ps
`include "rmu_regs.vh"
module rmu_remainder_unit (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // issue side
  input  wire        issue_valid,
  input  wire [1:0]  issue_op,
  input  wire [63:0] divisor_operand,
  input  wire [63:0] dividend_operand,
  input  wire [2:0]  operand_in_reg,
  input  wire [4:0]  divisor_operand_reg_idx,
  input  wire [4:0]  dividend_operand_reg_idx,
  input  wire [4:0]  dst_reg_idx,
  output reg         issue_ready_q,
  // result side
  output reg         result_valid_q,
  output reg  [63:0] result_data_q,
  output reg  [7:0]  result_fault_q,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_q,
  // interrupt
  output reg         irq_q
);
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_INT  = 6'b000010;
  localparam [5:0] ST_PRE  = 6'b000100;
  localparam [5:0] ST_RED  = 6'b001000;
  localparam [5:0] ST_POST = 6'b010000;
  localparam [5:0] ST_FIN  = 6'b100000;

  reg  [5:0]  state_q;
  reg  [6:0]  ctrl_q;
  reg  [3:0]  qbits_q;
  reg  [7:0]  exc_q;
  reg  [1:0]  ists_q;
  reg  [1:0]  ien_q;
  reg         long_q;
  reg         sign_q;
  reg         sgn_in_q;
  reg         signed_q;
  reg         lost_q;
  reg  [53:0] rx_q;
  reg  [52:0] dy_q;
  reg  [31:0] dvd_q;
  reg  [12:0] ex_q;
  reg  [12:0] ey_q;
  reg  [12:0] cnt_q;

  wire        is_int;
  wire        is_long;
  wire        start;
  wire        xs, ys, xz, yz, xi, yi, xn, yn, xsn, ysn, xd, yd;
  wire [12:0] xe, ye;
  wire [52:0] xm, ym;

  // operand classification for dividend and divisor
  assign is_int  = ~issue_op[1];
  assign is_long = (issue_op == `RMU_OP_REMRL);
  assign start   = issue_valid & issue_ready_q & state_q[0];

  rmu_fp_unpack u_unpack_dvd (
    .val    (dividend_operand),
    .is_long(is_long),
    .sign   (xs),
    .exp    (xe),
    .mant   (xm),
    .zero   (xz),
    .inf    (xi),
    .nan    (xn),
    .snan   (xsn),
    .denorm (xd)
  );

  rmu_fp_unpack u_unpack_dsr (
    .val    (divisor_operand),
    .is_long(is_long),
    .sign   (ys),
    .exp    (ye),
    .mant   (ym),
    .zero   (yz),
    .inf    (yi),
    .nan    (yn),
    .snan   (ysn),
    .denorm (yd)
  );

  // shared reduction step: integer partial remainder or real mantissa
  wire [53:0] step_a;
  wire [53:0] step_b;
  wire        step_ge;
  wire [53:0] step_diff;

  assign step_a = state_q[1] ? {21'h0, rx_q[31:0], dvd_q[31]} : rx_q;
  assign step_b = state_q[1] ? {22'h0, dy_q[31:0]} : {1'b0, dy_q};

  rmu_sub_step #(.W(54)) u_step (
    .minuend   (step_a),
    .subtrahend(step_b),
    .ge        (step_ge),
    .diff      (step_diff)
  );

  // remainder after this step and the look-ahead reduction
  wire [53:0] rem_n;
  wire [53:0] rem_tw;
  wire [54:0] tw_full;
  wire        q_round;
  wire        q_sticky;

  assign rem_n    = step_ge ? step_diff : step_a;
  assign rem_tw   = {rem_n[52:0], 1'b0};
  assign tw_full  = {1'b0, rem_tw} - {2'b00, dy_q};
  assign q_round  = ~tw_full[54];
  assign q_sticky = q_round ? (tw_full[53:0] != 54'h0) : (rem_n != 54'h0);

  // integer result from the final step
  wire [31:0] imag;
  wire [31:0] ires;
  wire        iovf;

  assign imag = rem_n[31:0];
  assign ires = sign_q ? (32'h0 - imag) : imag;
  assign iovf = signed_q & ~ctrl_q[`RMU_EXC_INT_OVF] & (sign_q == sgn_in_q) &
                (ires != 32'h0) & (ires[31] != sign_q);

  // odd register index on a long operand
  wire        misalign;
  assign misalign = is_long & ((operand_in_reg[0] & divisor_operand_reg_idx[0]) |
                               (operand_in_reg[1] & dividend_operand_reg_idx[0]) |
                               (operand_in_reg[2] & dst_reg_idx[0]));

  // special operand classes resolved without reduction
  reg         spec_hit;
  reg  [63:0] spec_res;
  reg  [7:0]  spec_exc;
  reg  [3:0]  spec_q;
  wire [63:0] qnan;
  wire [63:0] nan_src;
  wire [63:0] nan_quiet;

  assign qnan      = is_long ? `RMU_QNAN_LONG : `RMU_QNAN_SHORT;
  assign nan_src   = xn ? dividend_operand : divisor_operand;
  assign nan_quiet = is_long ? (nan_src | 64'h0008_0000_0000_0000) :
                               {32'h0, nan_src[31:0] | 32'h0040_0000};

  always @* begin
    spec_hit = 1'b1;
    spec_res = qnan;
    spec_exc = 8'h00;
    spec_q   = 4'h0;
    if (misalign) begin
      spec_exc[`RMU_EXC_ALIGN] = 1'b1;
    end else if (xn | yn) begin
      spec_res = nan_quiet;
      spec_exc[`RMU_EXC_INVALID] = xsn | ysn;
    end else if (ctrl_q[`RMU_CTRL_NORM_BIT] & (xd | yd)) begin
      spec_exc[`RMU_EXC_RESERVED] = 1'b1;
    end else if (xi) begin
      spec_exc[`RMU_EXC_INVALID] = 1'b1;
    end else if (yz) begin
      spec_exc[`RMU_EXC_INVALID] = xz;
      spec_exc[`RMU_EXC_ZDIV]    = ~xz;
    end else if (yi | xz) begin
      spec_res = is_long ? dividend_operand : {32'h0, dividend_operand[31:0]};
      spec_q   = {3'b000, ~xz};
    end else begin
      spec_hit = 1'b0;
    end
  end

  // result packing in the destination format
  wire [12:0] emin;
  wire [12:0] emax;
  wire [12:0] sexp;
  wire [63:0] pack;
  wire [7:0]  fexc;

  assign emin = long_q ? `RMU_EMIN_LONG : `RMU_EMIN_SHORT;
  assign emax = long_q ? `RMU_EMAX_LONG : `RMU_EMAX_SHORT;
  assign sexp = rx_q[52] ? (ex_q - `RMU_SHORT_BIAS_ADJ) : 13'h0000;
  assign pack = long_q ? {sign_q, (rx_q[52] ? ex_q[10:0] : 11'h000), rx_q[51:0]} :
                {32'h0, sign_q, sexp[7:0], rx_q[51:29]};
  assign fexc = {2'b00,
                 lost_q | (~long_q & (rx_q[28:0] != 29'h0)), 2'b00,
                 ~rx_q[52] & (rx_q != 54'h0),
                 ($signed(ex_q) > $signed(emax)), 1'b0};

  // issue, reduction and completion sequencing
  always @(posedge clk_sys) begin
    if (rst) begin
      state_q        <= ST_IDLE;
      issue_ready_q  <= 1'b0;
      result_valid_q <= 1'b0;
      result_data_q  <= 64'h0;
      result_fault_q <= 8'h00;
      qbits_q        <= 4'h0;
      exc_q          <= 8'h00;
      long_q         <= 1'b0;
      sign_q         <= 1'b0;
      sgn_in_q       <= 1'b0;
      signed_q       <= 1'b0;
      lost_q         <= 1'b0;
      rx_q           <= 54'h0;
      dy_q           <= 53'h0;
      dvd_q          <= 32'h0;
      ex_q           <= 13'h0;
      ey_q           <= 13'h0;
      cnt_q          <= 13'h0;
    end else begin
      result_valid_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          issue_ready_q <= 1'b1;
          if (start & is_int) begin
            // magnitudes of the operands, sign of the dividend kept
            signed_q      <= ~issue_op[0];
            sign_q        <= ~issue_op[0] & dividend_operand[31];
            sgn_in_q      <= ~issue_op[0] & divisor_operand[31];
            dvd_q         <= (~issue_op[0] & dividend_operand[31]) ?
                             (32'h0 - dividend_operand[31:0]) : dividend_operand[31:0];
            dy_q          <= {21'h0, (~issue_op[0] & divisor_operand[31]) ?
                             (32'h0 - divisor_operand[31:0]) : divisor_operand[31:0]};
            rx_q          <= 54'h0;
            cnt_q         <= 13'd31;
            if (divisor_operand[31:0] == 32'h0) begin
              result_valid_q <= 1'b1;
              result_data_q  <= {32'h0, dividend_operand[31:0]};
              exc_q          <= 8'h08;
              result_fault_q <= 8'h08 & ~{2'b00, ctrl_q[5:0]};
            end else begin
              issue_ready_q <= 1'b0;
              state_q       <= ST_INT;
            end
          end else if (start) begin
            long_q  <= is_long;
            sign_q  <= xs;
            lost_q  <= 1'b0;
            rx_q    <= {1'b0, xm};
            dy_q    <= ym;
            ex_q    <= xe;
            ey_q    <= ye;
            qbits_q <= spec_hit ? spec_q : 4'h0;
            if (spec_hit) begin
              result_valid_q <= 1'b1;
              result_data_q  <= spec_res;
              exc_q          <= spec_exc;
              result_fault_q <= spec_exc & ~{2'b00, ctrl_q[5:0]};
            end else begin
              issue_ready_q <= 1'b0;
              state_q       <= ST_PRE;
            end
          end
        end
        ST_INT: begin
          // one restoring division step per cycle, 32 in all
          rx_q  <= rem_n;
          dvd_q <= {dvd_q[30:0], 1'b0};
          cnt_q <= cnt_q - 13'd1;
          if (cnt_q == 13'd0) begin
            result_valid_q <= 1'b1;
            result_data_q  <= {32'h0, ires};
            exc_q          <= {7'h00, iovf};
            result_fault_q <= {7'h00, iovf};
            issue_ready_q  <= 1'b1;
            state_q        <= ST_IDLE;
          end
        end
        ST_PRE: begin
          // normalize unnormal mantissas so each step removes one bit
          if (~rx_q[52]) begin
            rx_q <= {rx_q[52:0], 1'b0};
            ex_q <= ex_q - 13'd1;
          end
          if (~dy_q[52]) begin
            dy_q <= {dy_q[51:0], 1'b0};
            ey_q <= ey_q - 13'd1;
          end
          if (rx_q[52] & dy_q[52]) begin
            cnt_q   <= ex_q - ey_q;
            state_q <= ST_RED;
          end
        end
        ST_RED: begin
          if (cnt_q[12]) begin
            // dividend below divisor: quotient zero, dividend is the remainder
            qbits_q <= {2'b00, (cnt_q == 13'h1FFF) & step_ge,
                        ~((cnt_q == 13'h1FFF) & step_ge & (step_diff == 54'h0))};
            state_q <= ST_POST;
          end else begin
            qbits_q[3:2] <= {qbits_q[2], step_ge};
            cnt_q        <= cnt_q - 13'd1;
            if (cnt_q == 13'd0) begin
              rx_q         <= rem_n;
              ex_q         <= ey_q;
              qbits_q[1:0] <= {q_round, q_sticky};
              state_q      <= ST_POST;
            end else begin
              rx_q <= rem_tw;
            end
          end
        end
        ST_POST: begin
          // renormalize, denormalizing below the format's least exponent
          if (rx_q == 54'h0) begin
            state_q <= ST_FIN;
          end else if ($signed(ex_q) < $signed(emin)) begin
            rx_q   <= {1'b0, rx_q[53:1]};
            lost_q <= lost_q | rx_q[0];
            ex_q   <= ex_q + 13'd1;
          end else if (~rx_q[52] & ($signed(ex_q) > $signed(emin))) begin
            rx_q <= {rx_q[52:0], 1'b0};
            ex_q <= ex_q - 13'd1;
          end else begin
            state_q <= ST_FIN;
          end
        end
        ST_FIN: begin
          result_valid_q <= 1'b1;
          result_data_q  <= pack;
          exc_q          <= fexc;
          result_fault_q <= fexc & ~{2'b00, ctrl_q[5:0]};
          issue_ready_q  <= 1'b1;
          state_q        <= ST_IDLE;
        end
        default: begin
          state_q       <= ST_IDLE;
          issue_ready_q <= 1'b0;
        end
      endcase
    end
  end

  // register writes, sticky events and interrupt level
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= `RMU_CTRL_RESET;
      ists_q <= 2'b00;
      ien_q  <= 2'b00;
      irq_q  <= 1'b0;
    end else begin
      if (reg_wr & (reg_addr == `RMU_ADDR_CTRL)) begin
        ctrl_q <= reg_wdata[6:0];
      end
      if (reg_wr & (reg_addr == `RMU_ADDR_IRQ_ENABLE)) begin
        ien_q <= reg_wdata[1:0];
      end
      // a new event wins over a clear in the same cycle
      ists_q <= (ists_q & ~((reg_wr & (reg_addr == `RMU_ADDR_IRQ_CLEAR)) ?
                            reg_wdata[1:0] : 2'b00)) |
                {result_valid_q & (result_fault_q != 8'h00), result_valid_q};
      irq_q  <= |(ists_q & ien_q);
    end
  end

  // read data one cycle after the read strobe
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_q <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `RMU_ADDR_CTRL:       reg_rdata_q <= {25'h0, ctrl_q};
        `RMU_ADDR_ASTAT:      reg_rdata_q <= {16'h0, exc_q, 1'b0, qbits_q, 3'b000};
        `RMU_ADDR_IRQ_STATUS: reg_rdata_q <= {30'h0, ists_q};
        `RMU_ADDR_IRQ_ENABLE: reg_rdata_q <= {30'h0, ien_q};
        default:              reg_rdata_q <= 32'h0;
      endcase
    end else begin
      reg_rdata_q <= 32'h0;
    end
  end
endmodule

// file: rtl/rmu_regs.vh
// register map, field positions and encodings of the remainder unit
`ifndef RMU_REGS_VH
`define RMU_REGS_VH
// register byte offsets
`define RMU_ADDR_CTRL       8'h00
`define RMU_ADDR_ASTAT      8'h04
`define RMU_ADDR_IRQ_STATUS 8'h08
`define RMU_ADDR_IRQ_CLEAR  8'h0C
`define RMU_ADDR_IRQ_ENABLE 8'h10
// arithmetic controls fields
`define RMU_CTRL_W          7
`define RMU_CTRL_RESET      7'h00
`define RMU_CTRL_NORM_BIT   6
// exception vector positions (bits 0..5 masked by ctrl bits 0..5)
`define RMU_EXC_INT_OVF     0
`define RMU_EXC_FLT_OVF     1
`define RMU_EXC_FLT_UNF     2
`define RMU_EXC_ZDIV        3
`define RMU_EXC_INVALID     4
`define RMU_EXC_INEXACT     5
`define RMU_EXC_RESERVED    6
`define RMU_EXC_ALIGN       7
// arithmetic status field positions
`define RMU_ASTAT_QS_LSB    3
`define RMU_ASTAT_EXC_LSB   8
// operation codes
`define RMU_OP_REMI         2'h0
`define RMU_OP_REMO         2'h1
`define RMU_OP_REMR         2'h2
`define RMU_OP_REMRL        2'h3
// exponent limits in the long-real scale
`define RMU_EMIN_LONG       13'h0001
`define RMU_EMAX_LONG       13'h07FE
`define RMU_EMIN_SHORT      13'h0381
`define RMU_EMAX_SHORT      13'h047E
`define RMU_SHORT_BIAS_ADJ  13'h0380
// default quiet NaN results
`define RMU_QNAN_LONG       64'h7FF8_0000_0000_0000
`define RMU_QNAN_SHORT      64'h0000_0000_7FC0_0000
`endif

// file: rtl/rmu_sub_step.v
// compare-and-subtract step shared by the integer and real reductions
`timescale 1ns/100ps
module rmu_sub_step #(
  parameter W = 54
) (
  // operands
  input  wire [W-1:0] minuend,
  input  wire [W-1:0] subtrahend,
  // results
  output wire         ge,
  output wire [W-1:0] diff
);
  wire [W:0] full;

  // borrow out clear means minuend >= subtrahend
  assign full = {1'b0, minuend} - {1'b0, subtrahend};
  assign ge   = ~full[W];
  assign diff = full[W-1:0];
endmodule

// file: rtl/rmu_fp_unpack.v
// splits a short or long real operand into class flags, exponent and mantissa
`timescale 1ns/100ps
`include "rmu_regs.vh"
module rmu_fp_unpack (
  // operand
  input  wire [63:0] val,
  input  wire        is_long,
  // fields in the long-real scale
  output wire        sign,
  output wire [12:0] exp,
  output wire [52:0] mant,
  // classes
  output wire        zero,
  output wire        inf,
  output wire        nan,
  output wire        snan,
  output wire        denorm
);
  wire [10:0] e11;
  wire [51:0] f52;
  wire        e_max;
  wire        e_zero;

  // short reals are widened exactly into the long layout
  assign e11    = is_long ? val[62:52] : {3'h0, val[30:23]};
  assign f52    = is_long ? val[51:0] : {val[22:0], 29'h0000_0000};
  assign sign   = is_long ? val[63] : val[31];
  assign e_max  = is_long ? (&val[62:52]) : (&val[30:23]);
  assign e_zero = (e11 == 11'h000);
  // denormals take the smallest exponent and no hidden bit
  assign exp    = (e_zero ? 13'h0001 : {2'b00, e11}) +
                  (is_long ? 13'h0000 : `RMU_SHORT_BIAS_ADJ);
  assign mant   = {~e_zero, f52};
  assign zero   = e_zero & (f52 == 52'h0);
  assign denorm = e_zero & (f52 != 52'h0);
  assign inf    = e_max & (f52 == 52'h0);
  assign nan    = e_max & (f52 != 52'h0);
  assign snan   = nan & ~f52[51];
endmodule

// file: bench/rmu_asserts.sv
// port-level checker for the remainder unit
`timescale 1ns/100ps
`include "rmu_regs.vh"
module rmu_asserts (
  // clock and reset
  input wire        clk_sys,
  input wire        rst,
  // issue side
  input wire        issue_valid,
  input wire [1:0]  issue_op,
  input wire [63:0] divisor_operand,
  input wire [63:0] dividend_operand,
  input wire [2:0]  operand_in_reg,
  input wire [4:0]  divisor_operand_reg_idx,
  input wire [4:0]  dividend_operand_reg_idx,
  input wire [4:0]  dst_reg_idx,
  input wire        issue_ready_q,
  // result side
  input wire        result_valid_q,
  input wire [63:0] result_data_q,
  input wire [7:0]  result_fault_q,
  // register port and interrupt
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata_q,
  input wire        irq_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a request taken and a nonzero integer divisor
  wire       take_w = issue_valid && issue_ready_q;
  wire       int_w  = take_w && !issue_op[1] && divisor_operand[31:0] != 32'h0000_0000;
  reg  [6:0] ctrl_q;
  reg  [1:0] op_q;
  // mirror of the control register and of the last taken operation
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= 7'h00;
      op_q   <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == `RMU_ADDR_CTRL) ctrl_q <= reg_wdata[6:0];
      if (take_w) op_q <= issue_op;
    end
  end
  int_busy_a: assert property (int_w |=> !issue_ready_q [*8])
    else $error("unit ready during integer reduction");
  int_lat_a: assert property (int_w |-> ##33 result_valid_q)
    else $error("integer result late or early");
  int_sign_a: assert property (int_w && issue_op == `RMU_OP_REMI |-> ##33
    (result_data_q[31:0] == 32'h0000_0000 || result_data_q[31] == $past(dividend_operand[31], 33)))
    else $error("signed remainder sign wrong");
  ord_range_a: assert property (int_w && issue_op == `RMU_OP_REMO |-> ##33
    result_data_q[31:0] < $past(divisor_operand[31:0], 33))
    else $error("ordinal remainder not below divisor");
  ovf_cause_a: assert property (result_valid_q && result_fault_q[0] |->
    op_q == `RMU_OP_REMI && !ctrl_q[0])
    else $error("integer overflow on wrong op or masked");
  mask_honour_a: assert property (result_valid_q |->
    (result_fault_q[5:0] & ctrl_q[5:0]) == 6'h00)
    else $error("masked exception became a fault");
  resv_mode_a: assert property (result_valid_q && result_fault_q[6] |-> ctrl_q[6])
    else $error("reserved fault without normalizing mode");
  odd_reg_a: assert property (take_w && issue_op == `RMU_OP_REMRL && operand_in_reg[0]
    && divisor_operand_reg_idx[0] |=> result_valid_q && result_fault_q[7])
    else $error("odd long register not refused");
  inf_div_a: assert property (take_w && issue_op == `RMU_OP_REMR
    && divisor_operand[30:0] == 31'h7F80_0000 && dividend_operand[30:23] != 8'hFF
    && dividend_operand[30:23] != 8'h00 |=> result_valid_q
    && result_data_q == {32'h0000_0000, $past(dividend_operand[31:0])})
    else $error("infinite divisor did not return dividend");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata_q == 32'h0000_0000)
    else $error("read data outside read answer");
  cover property (int_w);
  cover property (result_valid_q && result_fault_q != 8'h00);
  cover property ($rose(irq_q));
endmodule
bind rmu_remainder_unit rmu_asserts chk (.clk_sys(clk_sys), .rst(rst),
  .issue_valid(issue_valid), .issue_op(issue_op), .divisor_operand(divisor_operand),
  .dividend_operand(dividend_operand), .operand_in_reg(operand_in_reg),
  .divisor_operand_reg_idx(divisor_operand_reg_idx), .dividend_operand_reg_idx(dividend_operand_reg_idx), .dst_reg_idx(dst_reg_idx),
  .issue_ready_q(issue_ready_q), .result_valid_q(result_valid_q),
  .result_data_q(result_data_q), .result_fault_q(result_fault_q), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .irq_q(irq_q));

// file: bench/rmu_issuer.sv
// issue-side model that hands operands to the remainder unit
`timescale 1ns/100ps
module rmu_issuer (
  // clock and handshake
  input  wire        clk_sys,
  input  wire        issue_ready_q,
  input  wire        result_valid_q,
  // request
  output reg         issue_valid,
  output reg  [1:0]  issue_op,
  output reg  [63:0] divisor_operand,
  output reg  [63:0] dividend_operand,
  output reg  [2:0]  operand_in_reg,
  output reg  [4:0]  divisor_operand_reg_idx,
  output reg  [4:0]  dividend_operand_reg_idx,
  output reg  [4:0]  dst_reg_idx
);
  // idle values at time zero
  initial begin
    {issue_valid, issue_op, divisor_operand, dividend_operand} = 131'h0;
    {operand_in_reg, divisor_operand_reg_idx, dividend_operand_reg_idx, dst_reg_idx} = 18'h0;
  end
  // request held until taken, then the result pulse awaited
  task issue(input [1:0] op, input [63:0] dvs, input [63:0] dvd, input [4:0] idx,
             output reg ok);
    integer n;
    begin
      @(posedge clk_sys);
      issue_valid      <= 1'b1;
      issue_op         <= op;
      divisor_operand  <= dvs;
      dividend_operand <= dvd;
      operand_in_reg   <= 3'h7;
      divisor_operand_reg_idx     <= idx;
      dividend_operand_reg_idx     <= 5'h02;
      dst_reg_idx      <= 5'h04;
      n = 0;
      @(posedge clk_sys);
      while (issue_ready_q !== 1'b1 && n < 100) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      // released lines carry no stale operand
      issue_valid      <= 1'b0;
      divisor_operand  <= ~dvs;
      dividend_operand <= ~dvd;
      ok = 1'b0;
      n = 0;
      while (!ok && n < 3000) begin
        @(negedge clk_sys);
        ok = (result_valid_q === 1'b1);
        n = n + 1;
      end
    end
  endtask
endmodule

// file: bench/tb.sv
// self-checking bench for the remainder unit
`timescale 1ns/100ps
`include "rmu_regs.vh"
module tb;
  typedef struct packed {
    logic [1:0] op; logic [63:0] dvs; logic [63:0] dvd; logic [4:0] idx;
    logic [63:0] res; logic [7:0] flt; logic chk;
  } rmu_row_t;
  rmu_row_t    rows [0:15];
  logic        clk_sys, rst, reg_wr, reg_rd, ok, irq_q;
  logic        issue_valid, issue_ready_q, result_valid_q;
  logic [1:0]  issue_op;
  logic [2:0]  operand_in_reg;
  logic [4:0]  divisor_operand_reg_idx, dividend_operand_reg_idx, dst_reg_idx;
  logic [7:0]  reg_addr, result_fault_q;
  logic [31:0] reg_wdata, reg_rdata_q, d;
  logic [63:0] divisor_operand, dividend_operand, result_data_q;
  integer      fail_count = 0, num_checks = 0, cyc = 0, i;
  rmu_issuer iss (.clk_sys(clk_sys), .issue_ready_q(issue_ready_q),
    .result_valid_q(result_valid_q), .issue_valid(issue_valid), .issue_op(issue_op),
    .divisor_operand(divisor_operand), .dividend_operand(dividend_operand),
    .operand_in_reg(operand_in_reg), .divisor_operand_reg_idx(divisor_operand_reg_idx),
    .dividend_operand_reg_idx(dividend_operand_reg_idx), .dst_reg_idx(dst_reg_idx));
  rmu_remainder_unit uut (.clk_sys(clk_sys), .rst(rst), .issue_valid(issue_valid),
    .issue_op(issue_op), .divisor_operand(divisor_operand),
    .dividend_operand(dividend_operand), .operand_in_reg(operand_in_reg),
    .divisor_operand_reg_idx(divisor_operand_reg_idx), .dividend_operand_reg_idx(dividend_operand_reg_idx), .dst_reg_idx(dst_reg_idx),
    .issue_ready_q(issue_ready_q), .result_valid_q(result_valid_q),
    .result_data_q(result_data_q), .result_fault_q(result_fault_q), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .irq_q(irq_q));
  // clock generation
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // compare and count
  task chk(input [63:0] got, input [63:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks=%0d errors=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  // single-cycle register write and read
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] v);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      @(negedge clk_sys);
      v = reg_rdata_q;
    end
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end
  initial begin
    rows = '{
      '{2'h0, 64'h3, 64'h7, 5'h0, 64'h1, 8'h00, 1'b1},
      '{2'h0, 64'h3, 64'hFFFF_FFF9, 5'h0, 64'hFFFF_FFFF, 8'h00, 1'b1},
      '{2'h1, 64'h4, 64'hFFFF_FFF9, 5'h0, 64'h1, 8'h00, 1'b1},
      '{2'h2, 64'h4040_0000, 64'h40A0_0000, 5'h0, 64'h4000_0000, 8'h00, 1'b1},
      '{2'h2, 64'h4040_0000, 64'hC0A0_0000, 5'h0, 64'hC000_0000, 8'h00, 1'b1},
      '{2'h2, 64'h4040_0000, 64'hC0C0_0000, 5'h0, 64'h8000_0000, 8'h00, 1'b1},
      '{2'h2, 64'h7F80_0000, 64'h40A0_0000, 5'h0, 64'h40A0_0000, 8'h00, 1'b1},
      '{2'h2, 64'h4040_0000, 64'h7F80_0000, 5'h0, 64'h0, 8'h10, 1'b0},
      '{2'h2, 64'h0, 64'h40A0_0000, 5'h0, 64'h0, 8'h08, 1'b0},
      '{2'h2, 64'h4040_0000, 64'h7FA0_0000, 5'h0, 64'h0, 8'h10, 1'b0},
      '{2'h2, 64'h4040_0000, 64'h7FC0_0001, 5'h0, 64'h7FC0_0001, 8'h00, 1'b1},
      '{2'h3, 64'h4008_0000_0000_0000, 64'h4014_0000_0000_0000, 5'h0,
        64'h4000_0000_0000_0000, 8'h00, 1'b1},
      '{2'h3, 64'h4008_0000_0000_0000, 64'h4014_0000_0000_0000, 5'h1, 64'h0, 8'h80, 1'b0},
      '{2'h2, 64'h2, 64'h3, 5'h0, 64'h1, 8'h04, 1'b1},
      '{2'h0, 64'h0, 64'h7, 5'h0, 64'h7, 8'h08, 1'b1},
      '{2'h2, 64'h4040_0000, 64'h3F80_0000, 5'h0, 64'h3F80_0000, 8'h00, 1'b1}};
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 42'h0};
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`RMU_ADDR_CTRL, d);
    chk(64'(d), 64'h0);
    rd(8'h20, d);
    chk(64'(d), 64'h0);
    // table of ordinary operations
    for (i = 0; i < 16; i = i + 1) begin
      iss.issue(rows[i].op, rows[i].dvs, rows[i].dvd, rows[i].idx, ok);
      chk(64'(ok), 64'h1);
      if (rows[i].chk) chk(result_data_q, rows[i].res);
      chk(64'(result_fault_q), 64'(rows[i].flt));
    end
    // quotient bits of 5 rem 3
    iss.issue(`RMU_OP_REMR, 64'h4040_0000, 64'h40A0_0000, 5'h0, ok);
    rd(`RMU_ADDR_ASTAT, d);
    chk(64'(d[6:3]), 64'h7);
    // masked zero-divide, then normalizing mode with a denormal
    wr(`RMU_ADDR_CTRL, 32'h0000_0008);
    iss.issue(`RMU_OP_REMR, 64'h0, 64'h40A0_0000, 5'h0, ok);
    chk(result_data_q, `RMU_QNAN_SHORT);
    chk(64'(result_fault_q), 64'h0);
    wr(`RMU_ADDR_CTRL, 32'h0000_0040);
    iss.issue(`RMU_OP_REMR, 64'h4040_0000, 64'h3, 5'h0, ok);
    chk(64'(result_fault_q), 64'h40);
    wr(`RMU_ADDR_CTRL, 32'h0000_0000);
    // interrupt masked, enabled, cleared, raised again
    rd(`RMU_ADDR_IRQ_STATUS, d);
    chk(64'(d[1:0]), 64'h3);
    chk(64'(irq_q), 64'h0);
    wr(`RMU_ADDR_IRQ_ENABLE, 32'h0000_0002);
    repeat (3) @(negedge clk_sys);
    chk(64'(irq_q), 64'h1);
    wr(`RMU_ADDR_IRQ_CLEAR, 32'h0000_0003);
    repeat (3) @(negedge clk_sys);
    chk(64'(irq_q), 64'h0);
    wr(`RMU_ADDR_IRQ_ENABLE, 32'h0000_0001);
    iss.issue(`RMU_OP_REMI, 64'h3, 64'h7, 5'h0, ok);
    repeat (3) @(negedge clk_sys);
    chk(64'(irq_q), 64'h1);
    // reset in mid-run clears control and interrupt
    wr(`RMU_ADDR_CTRL, 32'h0000_003F);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`RMU_ADDR_CTRL, d);
    chk(64'(d), 64'h0);
    chk(64'(irq_q), 64'h0);
    complete_run;
  end
endmodule
